// file: rta_alias_map.sv
`timescale 1ns/1ps
`include "rta_consts.svh"

module rta_alias_map #(
  parameter int NUM_SLOTS  = 6,
  parameter int FIRST_SLOT = 2
) (
  input  wire logic              core_clk,       // 250 MHz core clock
  input  wire logic              reset,          // sync reset, high
  input  wire logic              psel,           // apb select
  input  wire logic              penable,        // apb enable
  input  wire logic              pwrite,         // apb direction
  input  wire logic [11:0]       paddr,          // apb byte address
  input  wire logic [31:0]       pwdata,         // apb write data
  input  wire logic [3:0]        pstrb,          // apb byte strobes
  output logic      [31:0]       prdata,         // apb read data
  output logic                   pready,         // apb ready
  output logic                   pslverr,        // apb error
  input  wire logic              req_valid,      // decoded address byte
  input  wire rta_pkg::rta_req_s req,            // its address and r/w
  output logic                   fwd_valid,      // to control channel
  output rta_pkg::rta_fwd_s      fwd,            // remapped transaction
  output logic                   local_valid,    // no alias matched
  output rta_pkg::rta_req_s      local_req,      // unchanged transaction
  input  wire logic              rmt_mbox_we,    // far-end mailbox write
  input  wire logic [7:0]        rmt_mbox_wdata, // far-end mailbox data
  output logic      [7:0]        mbox_value      // mailbox for far end
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  localparam int SW = 3;

  if (NUM_SLOTS < 1 || NUM_SLOTS + FIRST_SLOT > 8) begin : g_chk
    $error("rta_alias_map: slot range does not fit three bits");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic in_win(input logic [9:0] idx,
                                  input logic [9:0] base);
    in_win = (idx >= base) && (idx < base + 10'(NUM_SLOTS));
  endfunction : in_win

  function automatic logic [SW-1:0] win_off(input logic [9:0] idx,
                                            input logic [9:0] base);
    logic [9:0] d;
    d       = idx - base;
    win_off = d[SW-1:0];
  endfunction : win_off

  function automatic logic [SW-1:0] first_set(
    input logic [NUM_SLOTS-1:0] v);
    first_set = '0;
    for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = SW'(i);
      end
    end
  endfunction : first_set

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [6:0]    alias_r [NUM_SLOTS];
  logic [6:0]    phys_r  [NUM_SLOTS];
  logic [7:0]    mbox_r;
  logic [31:0]   prdata_r;
  logic          pready_r;
  logic          pslverr_r;
  logic          fwd_valid_r;
  rta_pkg::rta_fwd_s fwd_r;
  logic          local_valid_r;
  rta_pkg::rta_req_s local_r;
  logic          last_hit_r;
  logic [SW-1:0] last_slot_r;
  logic [3:0]    fwd_cnt_r;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire logic [9:0]    idx       = paddr[11:2];
  wire logic          alias_sel = in_win(idx, `RTA_IDX_ALIAS2);
  wire logic          phys_sel  = in_win(idx, `RTA_IDX_PHYS2);
  wire logic          mbox_sel  = (idx == `RTA_IDX_MBOX);
  wire logic          stat_sel  = (idx == `RTA_IDX_STATUS);
  wire logic          mapped    = alias_sel | phys_sel | mbox_sel
                                  | stat_sel;
  wire logic [SW-1:0] alias_off = win_off(idx, `RTA_IDX_ALIAS2);
  wire logic [SW-1:0] phys_off  = win_off(idx, `RTA_IDX_PHYS2);
  wire logic          setup     = psel && !penable;
  wire logic          wr_en     = psel && penable && pready_r && pwrite
                                  && mapped && pstrb[0];
  wire logic [7:0]    stat_byte = {last_hit_r, last_slot_r, 4'h0};

  wire logic [31:0] rd_word =
    alias_sel ? {24'h000000, alias_r[alias_off], 1'b0} :
    phys_sel  ? {24'h000000, phys_r[phys_off], 1'b0}   :
    mbox_sel  ? {24'h000000, mbox_r}                   :
    stat_sel  ? {20'h00000, fwd_cnt_r, stat_byte[7:4],
                 4'h0} : 32'h00000000;

  // ----------------------------------------------------------------
  // apb response, zero wait states
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup && !mapped;
      if (setup && !pwrite) begin
        prdata_r <= rd_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // alias and physical address slots
  // ----------------------------------------------------------------
  logic [NUM_SLOTS-1:0] hit_vec;

  for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot
    // zero alias is disabled
    assign hit_vec[g] = req_valid && (alias_r[g] != 7'h00)
                        && (alias_r[g] == req.addr);

    always_ff @(posedge core_clk) begin
      if (reset) begin
        alias_r[g] <= `RTA_ALIAS_RST;
        phys_r[g]  <= `RTA_PHYS_RST;
      end else begin
        if (wr_en && alias_sel && alias_off == SW'(g)) begin
          // bit 0 dropped on write
          alias_r[g] <= pwdata[`RTA_ADDR_MSB:`RTA_ADDR_LSB];
        end
        if (wr_en && phys_sel && phys_off == SW'(g)) begin
          phys_r[g] <= pwdata[`RTA_ADDR_MSB:`RTA_ADDR_LSB];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // mailbox, local apb write wins over far-end write
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mbox_r <= `RTA_MBOX_RST;
    end else if (wr_en && mbox_sel) begin
      mbox_r <= pwdata[7:0];
    end else if (rmt_mbox_we) begin
      mbox_r <= rmt_mbox_wdata;
    end
  end

  // ----------------------------------------------------------------
  // address substitution and forwarding
  // ----------------------------------------------------------------
  wire logic          any_hit  = |hit_vec;
  wire logic [SW-1:0] hit_idx  = first_set(hit_vec);
  wire logic [6:0]    exp_phys = phys_r[hit_idx];

  always_ff @(posedge core_clk) begin
    if (reset) begin
      fwd_valid_r   <= 1'b0;
      fwd_r         <= '0;
      local_valid_r <= 1'b0;
      local_r       <= '0;
    end else begin
      fwd_valid_r   <= any_hit;
      local_valid_r <= req_valid && !any_hit;
      if (any_hit) begin
        fwd_r.slot <= hit_idx + SW'(FIRST_SLOT);
        fwd_r.addr <= exp_phys;
        fwd_r.rd   <= req.rd;
      end
      if (req_valid && !any_hit) begin
        local_r <= req;
      end
    end
  end

  // ----------------------------------------------------------------
  // status
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      last_hit_r  <= 1'b0;
      last_slot_r <= '0;
      fwd_cnt_r   <= 4'h0;
    end else if (req_valid) begin
      last_hit_r <= any_hit;
      if (any_hit) begin
        last_slot_r <= hit_idx + SW'(FIRST_SLOT);
        fwd_cnt_r   <= fwd_cnt_r + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata      = prdata_r;
  assign pready      = pready_r;
  assign pslverr     = pslverr_r;
  assign fwd_valid   = fwd_valid_r;
  assign fwd         = fwd_r;
  assign local_valid = local_valid_r;
  assign local_req   = local_r;
  assign mbox_value  = mbox_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_alias_rd_lsb: assert property (
    psel && penable && pready && !pwrite && alias_sel |-> !prdata[0])
    else $error("alias read shows bit 0 set");

  a_alias_wr_back: assert property (
    wr_en && alias_sel
    |=> alias_r[$past(alias_off)] == $past(pwdata[7:1]))
    else $error("alias write not stored");

  a_zero_no_hit: assert property (
    req_valid && req.addr == 7'h00 |=> !fwd_valid && local_valid)
    else $error("address zero was forwarded");

  a_alias_after_rst: assert property (
    $past(reset) |-> alias_r[0] == 7'h00
                     && alias_r[NUM_SLOTS-1] == 7'h00 && !fwd_valid)
    else $error("alias not zero after reset");

  a_hit_fwd_addr: assert property (
    req_valid && any_hit |=> fwd_valid && fwd.addr == $past(exp_phys))
    else $error("forwarded address not the physical one");

  a_hit_fwd_slot: assert property (
    req_valid && any_hit
    |=> fwd.rd == $past(req.rd)
        && alias_r[fwd.slot - 3'(FIRST_SLOT)] == $past(req.addr))
    else $error("forwarded slot does not hold the alias");

  a_miss_local: assert property (
    req_valid && !any_hit |=> !fwd_valid && local_req == $past(req))
    else $error("missed transaction not passed locally");

  a_mbox_local_wr: assert property (
    wr_en && mbox_sel |=> mbox_value == $past(pwdata[7:0]))
    else $error("mailbox write not stored");

  a_mbox_far_wr: assert property (
    rmt_mbox_we && !(wr_en && mbox_sel)
    |=> mbox_value == $past(rmt_mbox_wdata))
    else $error("far-end mailbox write lost");

  a_phys_wr_back: assert property (
    wr_en && phys_sel
    |=> phys_r[$past(phys_off)] == $past(pwdata[7:1]))
    else $error("physical address write not stored");

  a_apb_ready: assert property (
    setup |=> pready ##1 !pready)
    else $error("apb ready not one access cycle");

  c_fwd_seen:   cover property (req_valid && any_hit ##1 fwd_valid);
  c_miss_seen:  cover property (req_valid && !any_hit ##1 local_valid);
  c_mbox_clash: cover property (rmt_mbox_we && wr_en && mbox_sel);
  c_bad_addr:   cover property (pready && pslverr);

endmodule : rta_alias_map

// file: rta_consts.svh
// Notes on behaviour
// - each alias slot keeps a 7-bit alias in bits 7..1, writable and readable
// - every incoming transaction address is compared with all alias slots
// - a match swaps the address for the paired physical address
// - an alias of zero never matches anything
// - all alias registers reset to zero, so no forwarding after reset
// - eight-bit mailbox byte, no effect, reads back last value written
// - mailbox reachable from controllers at both ends of the link
// - paired physical register keeps the remote 7-bit address in bits 7..1
// - substituted transaction is forwarded over the control channel
`ifndef RTA_CONSTS_SVH
`define RTA_CONSTS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define RTA_IDX_PHYS2   10'h00A
`define RTA_IDX_ALIAS2  10'h012
`define RTA_IDX_ALIAS3  10'h013
`define RTA_IDX_ALIAS4  10'h014
`define RTA_IDX_ALIAS5  10'h015
`define RTA_IDX_ALIAS6  10'h016
`define RTA_IDX_ALIAS7  10'h017
`define RTA_IDX_MBOX    10'h018
`define RTA_IDX_STATUS  10'h020

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define RTA_ADDR_MSB    7
`define RTA_ADDR_LSB    1
`define RTA_ALIAS_RST   7'h00
`define RTA_PHYS_RST    7'h00
`define RTA_MBOX_RST    8'h00
`define RTA_STAT_HIT    7
`define RTA_STAT_SLOT_L 4

`endif

// file: rta_far_model.sv
`timescale 1ns/1ps

module rta_far_model (
  input  wire logic              core_clk,   // core clock
  output logic                   req_valid,  // decoded address byte
  output rta_pkg::rta_req_s      req,        // address and r/w bit
  output logic                   mbox_we,    // far-end mailbox write
  output logic      [7:0]        mbox_wdata  // far-end mailbox data
);
  initial begin
    req_valid  = 1'b0;
    req        = '0;
    mbox_we    = 1'b0;
    mbox_wdata = 8'h00;
  end

  // one transaction per cycle, no gaps needed
  task automatic send(input logic [6:0] a, input logic rd);
    req_valid <= 1'b1;
    req       <= {a, rd};
    @(posedge core_clk);
  endtask : send

  // released lines show a changed pattern, not the last value
  task automatic idle();
    req_valid  <= 1'b0;
    req        <= ~req;
    mbox_we    <= 1'b0;
    mbox_wdata <= ~mbox_wdata;
    @(posedge core_clk);
  endtask : idle

  task automatic mbox_write(input logic [7:0] d);
    mbox_we    <= 1'b1;
    mbox_wdata <= d;
    @(posedge core_clk);
  endtask : mbox_write
endmodule : rta_far_model

// file: rta_pkg.sv
package rta_pkg;

  // ----------------------------------------------------------------
  // transaction carriers
  // ----------------------------------------------------------------
  typedef logic [6:0] rta_addr_t;

  typedef struct packed {
    rta_addr_t addr;   // 7-bit target address
    logic      rd;     // read/write bit of the address byte
  } rta_req_s;

  typedef struct packed {
    logic [2:0] slot;  // alias slot that matched
    rta_addr_t  addr;  // substituted physical address
    logic       rd;    // read/write bit, passed through
  } rta_fwd_s;

endpackage : rta_pkg

// file: tb_remote_target_alias_map.sv
`timescale 1ns/1ps
`include "rta_consts.svh"

module tb_remote_target_alias_map;
  logic              core_clk, reset, psel, penable, pwrite, pready;
  logic              pslverr, req_valid, rmt_mbox_we, fwd_valid;
  logic              local_valid;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata;
  logic [3:0]        pstrb;
  logic [7:0]        rmt_mbox_wdata, mbox_value, d;
  rta_pkg::rta_req_s req, local_req;
  rta_pkg::rta_fwd_s fwd;
  logic [6:0]        al [8];
  logic [6:0]        phys [8];
  logic [32:0]       exp_ap [$];
  rta_pkg::rta_fwd_s exp_fwd [$];
  rta_pkg::rta_req_s exp_loc [$];
  int                bad_count = 0;
  int                n_compared = 0;
  int                hits = 0;
  logic              lhit = 1'b0;
  logic [2:0]        lslot = 3'h0;

  initial core_clk = 1'b0;
  always #2 core_clk = ~core_clk;

  rta_alias_map DUT (.core_clk, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .req_valid, .req,
    .fwd_valid, .fwd, .local_valid, .local_req, .rmt_mbox_we,
    .rmt_mbox_wdata, .mbox_value);

  rta_far_model far (.core_clk, .req_valid, .req, .mbox_we(rmt_mbox_we),
    .mbox_wdata(rmt_mbox_wdata));

  // -----
  // checking and closing
  // -----
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    if (bad_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  // -----
  // drivers that note expectations
  // -----
  task automatic apb(input logic wr, input logic [9:0] idx,
                     input logic [31:0] dat, input logic [3:0] s,
                     input logic [32:0] e);
    int n;
    exp_ap.push_back(e);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {idx, 2'b00};
    pwdata <= dat;
    pstrb  <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      check(64'h1, 64'h0);
      report_and_stop();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  // reference decode: lowest nonzero matching slot wins
  task automatic tx(input logic [6:0] a, input logic rd);
    int h;
    h = -1;
    for (int s = 7; s >= 2; s--)
      if (al[s] != 7'h00 && al[s] == a) h = s;
    lhit = (h >= 0);
    if (h >= 0) begin
      exp_fwd.push_back({3'(h), phys[h], rd});
      hits++;
      lslot = 3'(h);
    end else exp_loc.push_back({a, rd});
    far.send(a, rd);
  endtask : tx

  // -----
  // output monitor
  // -----
  always @(posedge core_clk) begin
    if (!reset && psel && penable && pready === 1'b1) begin
      if (exp_ap.size() == 0) check(64'h1, 64'h0);
      else check({pwrite ? 32'h0 : prdata, pslverr},
                 exp_ap.pop_front());
    end
    if (!reset && fwd_valid === 1'b1) begin
      if (exp_fwd.size() == 0) check(64'h1, 64'h0);
      else check(64'(fwd), 64'(exp_fwd.pop_front()));
    end
    if (!reset && local_valid === 1'b1) begin
      if (exp_loc.size() == 0) check(64'h1, 64'h0);
      else check(64'(local_req), 64'(exp_loc.pop_front()));
    end
  end

  // -----
  // main sequence
  // -----
  initial begin
    reset   = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    pstrb   = 4'h0;
    foreach (al[i]) al[i] = 7'h00;
    foreach (phys[i]) phys[i] = 7'h00;
    void'($urandom(32'h3B5DD500));
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    for (int s = 2; s <= 7; s++) begin
      apb(0, `RTA_IDX_ALIAS2 + 10'(s - 2), 32'h0, 4'hF, 33'h0);
      apb(0, `RTA_IDX_PHYS2 + 10'(s - 2), 32'h0, 4'hF, 33'h0);
    end
    apb(0, `RTA_IDX_MBOX, 32'h0, 4'hF, 33'h0);
    tx(7'($urandom), 1'b1);
    tx(7'h00, 1'b0);
    far.idle();
    for (int s = 2; s <= 7; s++) begin
      al[s]   = 7'h40 + 7'(s);
      phys[s] = 7'($urandom_range(1, 127));
      apb(1, `RTA_IDX_ALIAS2 + 10'(s - 2), {24'($urandom), al[s], 1'b1},
          4'hF, 33'h0);
      apb(1, `RTA_IDX_PHYS2 + 10'(s - 2), {24'($urandom), phys[s], 1'b1},
          4'hF, 33'h0);
      apb(0, `RTA_IDX_ALIAS2 + 10'(s - 2), 32'h0, 4'hF,
          {24'h0, al[s], 2'b00});
      apb(0, `RTA_IDX_PHYS2 + 10'(s - 2), 32'h0, 4'hF,
          {24'h0, phys[s], 2'b00});
    end
    for (int s = 2; s <= 7; s++) tx(al[s], 1'($urandom));
    repeat (4) tx(7'($urandom_range(0, 63)), 1'($urandom));
    far.idle();
    al[5] = al[3];
    apb(1, `RTA_IDX_ALIAS5, {24'h0, al[5], 1'b0}, 4'hF, 33'h0);
    tx(al[3], 1'b1);
    far.idle();
    al[3] = 7'h00;
    apb(1, `RTA_IDX_ALIAS3, 32'h0, 4'hF, 33'h0);
    tx(al[5], 1'b0);
    tx(7'h00, 1'b1);
    far.idle();
    apb(1, `RTA_IDX_ALIAS2, 32'hFE, 4'hE, 33'h0);
    apb(0, `RTA_IDX_ALIAS2, 32'h0, 4'hF, {24'h0, al[2], 2'b00});
    apb(1, 10'h3FF, 32'hFF, 4'hF, 33'h1);
    apb(0, 10'h3FF, 32'h0, 4'hF, 33'h1);
    d = 8'($urandom);
    apb(1, `RTA_IDX_MBOX, {24'h0, d}, 4'hF, 33'h0);
    apb(0, `RTA_IDX_MBOX, 32'h0, 4'hF, {24'h0, d, 1'b0});
    check(64'(mbox_value), 64'(d));
    d = ~d;
    far.mbox_write(d);
    far.idle();
    check(64'(mbox_value), 64'(d));
    apb(0, `RTA_IDX_MBOX, 32'h0, 4'hF, {24'h0, d, 1'b0});
    apb(0, `RTA_IDX_STATUS, 32'h0, 4'hF,
        {20'h0, 4'(hits), lhit, lslot, 4'h0, 1'b0});
    repeat (3) @(posedge core_clk);
    check(64'(exp_ap.size() + exp_fwd.size() + exp_loc.size()), 64'h0);
    report_and_stop();
  end
endmodule : tb_remote_target_alias_map
